/* src/cdaw_core.sv */
// decoder and executor for the control and wide-arithmetic groups
//
// Behaviour
// - byte 27 decimal-adjusts A in 4 states; S Z H C, parity, N kept
// - ED 44 negates A in 8 states; N set, overflow, S Z H C
// - byte 3F toggles carry in 4 states, clears N
// - byte 00 takes 4 states and changes nothing
// - F3 clears, FB sets the interrupt enable latch, 4 states each
// - no interrupt sampling at the end of F3 or FB
// - plain pair add into pointer pair: 11 states, N clear, carry
// - ED add with carry into pointer pair: 15 states, S Z V C, N clear
// - ED subtract with borrow from pointer pair: 15 states, N set
// - DD pair add into first index: 15 states, N clear, carry
// - FD pair add into second index: same as the first index form
// - plain pair step up or down: 6 states, no flag change
// - DD or FD then 23 or 2B steps an index in 10 states
// - pair field 00 first, 01 second, 10 pointer, 11 stack pointer
// - under DD or FD, field 10 names the index register itself
`timescale 1ns/100ps
`default_nettype none
module cdaw_core
    import cdaw_pkg::*;
(
    // clock and reset
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RST_N,
    // instruction byte stream
    input  wire logic       I_OP_VALID,
    input  wire logic [7:0] I_OP_BYTE,
    output logic            O_OP_READY,
    // architectural state
    output var cdaw_regs_s  O_REGS,
    output logic            O_IEN,
    output logic [1:0]      O_IMODE,
    output logic            O_HALTED,
    // instruction end
    output logic            O_DONE,
    output logic            O_INT_SAMPLE
);
    // ======================================================
    // reset release
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ======================================================
    // helpers
    function automatic logic [4:0] states_of(
        input logic [7:0] p,
        input logic [7:0] o
    );
        logic add_form;
        add_form = (o[7:6] == 2'b00) && (o[3:0] == 4'h9);
        if (p == PFX_ED)
            return (o[7:6] == 2'b01 && o[2:0] == 3'b010)
                ? T_WIDE : T_PFX;
        if (p != PFX_NONE)
            return add_form ? T_WIDE
                : ((o == OP_INCX || o == OP_DECX) ? T_XSTEP : T_PFX);
        if (add_form)
            return T_ADD16;
        if (o[7:6] == 2'b00 && o[2:0] == 3'b011)
            return T_STEP;
        return T_SHORT;
    endfunction

    // field 10 names the pointer pair or the selected index
    function automatic logic [15:0] pair_read(
        input cdaw_regs_s r,
        input logic [1:0] field,
        input logic [1:0] xs
    );
        unique case (field)
            2'b00: return r.first_pair;
            2'b01: return r.second_pair;
            2'b10: return (xs == 2'd1) ? r.first_index_register
                : (xs == 2'd2) ? r.second_index_register
                : r.primary_pointer_pair;
            default: return r.stack_pointer;
        endcase
    endfunction

    function automatic cdaw_regs_s pair_write(
        input cdaw_regs_s r,
        input logic [1:0] field,
        input logic [1:0] xs,
        input logic [15:0] v
    );
        cdaw_regs_s w;
        w = r;
        unique case (field)
            2'b00: w.first_pair = v;
            2'b01: w.second_pair = v;
            2'b10: begin
                if (xs == 2'd1)
                    w.first_index_register = v;
                else if (xs == 2'd2)
                    w.second_index_register = v;
                else
                    w.primary_pointer_pair = v;
            end
            default: w.stack_pointer = v;
        endcase
        return w;
    endfunction

    // ======================================================
    // sequencing
    cdaw_state_e state;
    logic [4:0]  cnt;
    logic [4:0]  tot;
    logic [7:0]  pfx;
    logic [7:0]  op;
    logic        take;
    logic        done;
    logic        is_prefix;

    assign O_OP_READY = (state == ST_FETCH)
        || (state == ST_PREFIX && cnt == T_M1);
    assign take = I_OP_VALID && O_OP_READY;
    assign done = (state == ST_EXEC) && (cnt == tot - 5'd1);
    assign is_prefix = (I_OP_BYTE == PFX_ED)
        || (I_OP_BYTE == PFX_DD) || (I_OP_BYTE == PFX_FD);

    // each clock is one state; a second byte waits for the first M1
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_FETCH;
            cnt <= 5'h00;
            tot <= T_SHORT;
            pfx <= PFX_NONE;
            op <= OP_IDLE;
        end else begin
            unique case (state)
                ST_FETCH: begin
                    if (take) begin
                        cnt <= 5'h01;
                        if (is_prefix) begin
                            pfx <= I_OP_BYTE;
                            state <= ST_PREFIX;
                        end else begin
                            pfx <= PFX_NONE;
                            op <= I_OP_BYTE;
                            tot <= states_of(PFX_NONE, I_OP_BYTE);
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_PREFIX: begin
                    if (take) begin
                        op <= I_OP_BYTE;
                        tot <= states_of(pfx, I_OP_BYTE);
                        cnt <= T_M1 + 5'd1;
                        state <= ST_EXEC;
                    end else if (cnt != T_M1) begin
                        cnt <= cnt + 5'd1;
                    end
                end
                ST_EXEC: begin
                    cnt <= cnt + 5'd1;
                    if (done)
                        state <= (pfx == PFX_NONE && op == OP_HALT)
                            ? ST_HALT : ST_FETCH;
                end
                ST_HALT: begin
                    // no wake logic here: only reset leaves halt
                end
            endcase
        end
    end

    // ======================================================
    // decode of the instruction in flight
    logic [1:0]  xs;
    logic [1:0]  field;
    logic        plain;
    logic        add16;
    logic        step16;
    logic        wide_ed;
    logic        latch_op;
    cdaw_a8op_e  a8op;
    cdaw_a16op_e a16op;

    assign plain = (pfx == PFX_NONE);
    assign xs = (pfx == PFX_DD) ? 2'd1 : (pfx == PFX_FD) ? 2'd2 : 2'd0;
    assign field = op[5:4];
    assign add16 = (plain || xs != 2'd0)
        && op[7:6] == 2'b00 && op[3:0] == 4'h9;
    assign step16 = op[7:6] == 2'b00 && op[2:0] == 3'b011
        && (plain || (xs != 2'd0 && field == 2'b10));
    assign wide_ed = (pfx == PFX_ED) && op[7:6] == 2'b01
        && op[2:0] == 3'b010;
    assign latch_op = plain && (op == OP_IOF || op == OP_ION);

    always_comb begin
        a8op = A8_PASS;
        if (plain && op == OP_ADJ)
            a8op = A8_ADJ;
        else if (plain && op == OP_INV)
            a8op = A8_INV;
        else if (pfx == PFX_ED && op == OP_TWO)
            a8op = A8_TWO;
        else if (plain && op == OP_TGL)
            a8op = A8_TGL;
        else if (plain && op == OP_SET)
            a8op = A8_SET;
    end

    always_comb begin
        if (step16)
            a16op = op[3] ? A16_DEC : A16_INC;
        else if (wide_ed)
            a16op = op[3] ? A16_ADC : A16_SUB;
        else
            a16op = A16_ADD;
    end

    // ======================================================
    // datapath
    cdaw_regs_s  regs;
    logic [7:0]  a8_acc;
    logic [7:0]  a8_flags;
    logic [15:0] w_a;
    logic [15:0] w_b;
    logic [15:0] w_sum;
    logic        w_carry;
    logic        w_ovf;

    assign w_a = step16 ? pair_read(regs, field, xs)
        : pair_read(regs, 2'b10, xs);
    assign w_b = pair_read(regs, field, xs);

    cdaw_alu8 u_alu8 (
        .i_op    (a8op),
        .i_acc   (regs.acc),
        .i_flags (regs.flags),
        .o_acc   (a8_acc),
        .o_flags (a8_flags)
    );

    cdaw_alu16 #(
        .W (16)
    ) u_alu16 (
        .i_op    (a16op),
        .i_cin   (regs.flags[FLAG_C]),
        .i_a     (w_a),
        .i_b     (w_b),
        .o_sum   (w_sum),
        .o_carry (w_carry),
        .o_ovf   (w_ovf)
    );

    // ======================================================
    // register write-back at the last state
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            regs <= '{RST_ACC, RST_FLAGS, RST_PAIR, RST_PAIR,
                RST_PAIR, RST_SP, RST_PAIR, RST_PAIR};
        end else if (done) begin
            if (a8op != A8_PASS) begin
                regs.acc <= a8_acc;
                regs.flags <= a8_flags;
            end else if (step16) begin
                regs <= pair_write(regs, field, xs, w_sum);
            end else if (add16) begin
                // H is undefined here and simply kept
                regs <= pair_write(regs, 2'b10, xs, w_sum);
                regs.flags[FLAG_C] <= w_carry;
                regs.flags[FLAG_N] <= 1'b0;
            end else if (wide_ed) begin
                regs.primary_pointer_pair <= w_sum;
                regs.flags[FLAG_S] <= w_sum[15];
                regs.flags[FLAG_Z] <= (w_sum == 16'h0000);
                regs.flags[FLAG_PV] <= w_ovf;
                regs.flags[FLAG_C] <= w_carry;
                regs.flags[FLAG_N] <= (a16op == A16_SUB);
            end
        end
    end

    // ======================================================
    // interrupt controls
    logic       ien;
    logic [1:0] imode;
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ien <= 1'b0;
            imode <= 2'd0;
        end else if (done) begin
            if (plain && op == OP_IOF)
                ien <= 1'b0;
            if (plain && op == OP_ION)
                ien <= 1'b1;
            if (pfx == PFX_ED && op == OP_MD0)
                imode <= 2'd0;
            if (pfx == PFX_ED && op == OP_MD1)
                imode <= 2'd1;
            if (pfx == PFX_ED && op == OP_MD2)
                imode <= 2'd2;
        end
    end

    // ======================================================
    // outputs
    assign O_REGS = regs;
    assign O_IEN = ien;
    assign O_IMODE = imode;
    assign O_HALTED = (state == ST_HALT);
    assign O_DONE = done;
    // one more instruction must run before a freshly set latch acts
    assign O_INT_SAMPLE = done && ien && !latch_op;

    // ======================================================
    // checks
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!rst_n);

    sequence s_take(logic [7:0] b);
        take && state == ST_FETCH && I_OP_BYTE == b;
    endsequence
    sequence s_pair(logic [7:0] p, logic [7:0] b);
        s_take(p) ##4 (take && I_OP_BYTE == b);
    endsequence

    decimal_adjust_a: assert property (s_take(OP_ADJ) |-> ##3 done
        ##1 regs.flags[FLAG_N] == $past(regs.flags[FLAG_N], 4))
        else $error("decimal adjust timing or N flag wrong");
    invert_acc_a: assert property (s_take(OP_INV) |-> ##4
        regs.acc == ~$past(regs.acc, 4) && regs.flags[FLAG_H]
        && regs.flags[FLAG_N])
        else $error("accumulator invert wrong");
    negate_acc_a: assert property (s_pair(PFX_ED, OP_TWO) |-> ##3
        done ##1 regs.acc == 8'h00 - $past(regs.acc, 4))
        else $error("accumulator negate wrong");
    carry_toggle_a: assert property (s_take(OP_TGL) |-> ##4
        regs.flags[FLAG_C] != $past(regs.flags[FLAG_C], 4)
        && !regs.flags[FLAG_N])
        else $error("carry toggle wrong");
    carry_force_a: assert property (s_take(OP_SET) |-> ##4
        regs.flags[FLAG_C] && !regs.flags[FLAG_H] && !regs.flags[FLAG_N])
        else $error("carry force wrong");
    idle_timing_a: assert property (s_take(OP_IDLE) |->
        !done [*3] ##1 done ##1 $stable(regs))
        else $error("idle instruction wrong");
    halt_entry_a: assert property (s_take(OP_HALT) |-> ##4
        O_HALTED && $stable(regs.flags))
        else $error("halt entry wrong");
    latch_set_a: assert property (s_take(OP_ION) |-> ##3
        (done && !O_INT_SAMPLE) ##1 ien)
        else $error("latch set or sampling wrong");
    mode_select_a: assert property (s_pair(PFX_ED, OP_MD1) |-> ##4
        imode == 2'd1 && $stable(regs.flags))
        else $error("interrupt mode select wrong");
    pointer_add_a: assert property (s_take(8'h09) |-> ##10 done
        ##1 regs.primary_pointer_pair == 16'($past(
        regs.primary_pointer_pair, 11) + $past(regs.first_pair, 11)))
        else $error("pointer pair add wrong");
    index_step_a: assert property (s_pair(PFX_DD, OP_INCX) |-> ##5
        done ##1 regs.first_index_register
        == 16'($past(regs.first_index_register, 7) + 16'h0001))
        else $error("index step wrong");
endmodule // cdaw_core
`default_nettype wire

/* src/cdaw_pkg.sv */
// package: constants and types of the arithmetic and control decoder
package cdaw_pkg;
    // ======================================================
    // flag register bit positions
    localparam int FLAG_S  = 7;
    localparam int FLAG_Z  = 6;
    localparam int FLAG_H  = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N  = 1;
    localparam int FLAG_C  = 0;
    // ======================================================
    // prefix and opcode bytes
    localparam logic [7:0] PFX_NONE = 8'h00;
    localparam logic [7:0] PFX_ED   = 8'hED;
    localparam logic [7:0] PFX_DD   = 8'hDD;
    localparam logic [7:0] PFX_FD   = 8'hFD;
    localparam logic [7:0] OP_ADJ   = 8'h27;
    localparam logic [7:0] OP_INV   = 8'h2F;
    localparam logic [7:0] OP_TGL   = 8'h3F;
    localparam logic [7:0] OP_SET   = 8'h37;
    localparam logic [7:0] OP_IDLE  = 8'h00;
    localparam logic [7:0] OP_HALT  = 8'h76;
    localparam logic [7:0] OP_IOF   = 8'hF3;
    localparam logic [7:0] OP_ION   = 8'hFB;
    localparam logic [7:0] OP_TWO   = 8'h44;
    localparam logic [7:0] OP_MD0   = 8'h46;
    localparam logic [7:0] OP_MD1   = 8'h56;
    localparam logic [7:0] OP_MD2   = 8'h5E;
    localparam logic [7:0] OP_INCX  = 8'h23;
    localparam logic [7:0] OP_DECX  = 8'h2B;
    // ======================================================
    // clock states per instruction
    localparam logic [4:0] T_SHORT = 5'h04;
    localparam logic [4:0] T_PFX   = 5'h08;
    localparam logic [4:0] T_ADD16 = 5'h0B;
    localparam logic [4:0] T_WIDE  = 5'h0F;
    localparam logic [4:0] T_STEP  = 5'h06;
    localparam logic [4:0] T_XSTEP = 5'h0A;
    localparam logic [4:0] T_M1    = 5'h04;
    // ======================================================
    // reset values
    localparam logic [7:0]  RST_ACC   = 8'hFF;
    localparam logic [7:0]  RST_FLAGS = 8'hFF;
    localparam logic [15:0] RST_PAIR  = 16'h0000;
    localparam logic [15:0] RST_SP    = 16'hFFFF;
    // ======================================================
    // types
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00, ST_PREFIX = 2'b01,
        ST_EXEC  = 2'b10, ST_HALT   = 2'b11
    } cdaw_state_e;
    typedef enum logic [2:0] {
        A8_ADJ = 3'b000, A8_INV = 3'b001, A8_TWO = 3'b010,
        A8_TGL = 3'b011, A8_SET = 3'b100, A8_PASS = 3'b101
    } cdaw_a8op_e;
    typedef enum logic [2:0] {
        A16_ADD = 3'b000, A16_ADC = 3'b001, A16_SUB = 3'b010,
        A16_INC = 3'b011, A16_DEC = 3'b100
    } cdaw_a16op_e;
    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  flags;
        logic [15:0] first_pair;
        logic [15:0] second_pair;
        logic [15:0] primary_pointer_pair;
        logic [15:0] stack_pointer;
        logic [15:0] first_index_register;
        logic [15:0] second_index_register;
    } cdaw_regs_s;
endpackage

/* src/cdaw_alu8.sv */
// accumulator and carry-flag operations
`timescale 1ns/100ps
`default_nettype none
module cdaw_alu8
    import cdaw_pkg::*;
(
    // operation
    input  wire cdaw_a8op_e i_op,
    // operands
    input  wire logic [7:0] i_acc,
    input  wire logic [7:0] i_flags,
    // results
    output logic [7:0]      o_acc,
    output logic [7:0]      o_flags
);
    // ======================================================
    // result
    always_comb begin
        logic [7:0] corr;
        corr = 8'h00;
        o_acc = i_acc;
        o_flags = i_flags;
        unique case (i_op)
            A8_ADJ: begin
                if (i_flags[FLAG_H] || i_acc[3:0] > 4'h9)
                    corr[3:0] = 4'h6;
                if (i_flags[FLAG_C] || i_acc > 8'h99)
                    corr[7:4] = 4'h6;
                o_acc = i_flags[FLAG_N] ? i_acc - corr : i_acc + corr;
                o_flags[FLAG_C] = i_flags[FLAG_C] | (i_acc > 8'h99);
                o_flags[FLAG_H] = i_flags[FLAG_N]
                    ? (i_flags[FLAG_H] && i_acc[3:0] < 4'h6)
                    : (i_acc[3:0] > 4'h9);
                // parity: even count of ones sets the flag
                o_flags[FLAG_PV] = ~^o_acc;
            end
            A8_INV: begin
                o_acc = ~i_acc;
                o_flags[FLAG_H] = 1'b1;
                o_flags[FLAG_N] = 1'b1;
            end
            A8_TWO: begin
                o_acc = 8'h00 - i_acc;
                o_flags[FLAG_H]  = (i_acc[3:0] != 4'h0);
                o_flags[FLAG_PV] = (i_acc == 8'h80);
                o_flags[FLAG_C]  = (i_acc != 8'h00);
                o_flags[FLAG_N]  = 1'b1;
            end
            A8_TGL: begin
                o_flags[FLAG_C] = ~i_flags[FLAG_C];
                o_flags[FLAG_N] = 1'b0;
            end
            A8_SET: begin
                o_flags[FLAG_C] = 1'b1;
                o_flags[FLAG_H] = 1'b0;
                o_flags[FLAG_N] = 1'b0;
            end
            default: begin
            end
        endcase
        if (i_op == A8_ADJ || i_op == A8_TWO) begin
            o_flags[FLAG_S] = o_acc[7];
            o_flags[FLAG_Z] = (o_acc == 8'h00);
        end
    end
endmodule // cdaw_alu8
`default_nettype wire

/* src/cdaw_alu16.sv */
// sixteen-bit add, subtract and step unit
`timescale 1ns/100ps
`default_nettype none
module cdaw_alu16
    import cdaw_pkg::*;
#(
    parameter int W = 16
) (
    // operation
    input  wire cdaw_a16op_e  i_op,
    input  wire logic         i_cin,
    // operands
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_b,
    // results
    output logic [W-1:0]      o_sum,
    output logic              o_carry,
    output logic              o_ovf
);
    if (W < 2) begin : g_bad_width
        $error("cdaw_alu16: width below two");
    end

    logic [W:0] wide;
    logic [W:0] ext_a;
    logic [W:0] ext_b;
    logic [W:0] ext_c;

    assign ext_a = {1'b0, i_a};
    assign ext_b = {1'b0, i_b};
    assign ext_c = {{W{1'b0}}, i_cin};

    // ======================================================
    // sum and flags
    always_comb begin
        unique case (i_op)
            A16_ADD: wide = ext_a + ext_b;
            A16_ADC: wide = ext_a + ext_b + ext_c;
            A16_SUB: wide = ext_a - ext_b - ext_c;
            A16_INC: wide = ext_a + {{W{1'b0}}, 1'b1};
            A16_DEC: wide = ext_a - {{W{1'b0}}, 1'b1};
            default: wide = ext_a;
        endcase
    end

    assign o_sum   = wide[W-1:0];
    // the borrow of a subtract lands in the top bit as well
    assign o_carry = wide[W];
    assign o_ovf   = (i_op == A16_SUB)
        ? (i_a[W-1] != i_b[W-1]) && (o_sum[W-1] != i_a[W-1])
        : (i_a[W-1] == i_b[W-1]) && (o_sum[W-1] != i_a[W-1]);
endmodule // cdaw_alu16
`default_nettype wire

/* testbench/cdaw_prog_mem.sv */
// program memory model feeding instruction bytes to the core
`timescale 1ns/100ps
`default_nettype none
module cdaw_prog_mem (
    // clock, reset and program
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_go,
    input  wire logic [15:0] i_prog,
    input  wire logic [1:0]  i_len,
    input  wire logic [3:0]  i_gap,
    // byte stream
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic [7:0]       o_byte
);
    logic [1:0] idx;
    logic [3:0] wait_cnt;
    logic [7:0] last;
    // =====================================================
    // offer
    // an idle line shows the inverse of its last byte, not a stale copy
    assign o_byte = o_valid ? (idx[0] ? i_prog[15:8] : i_prog[7:0]) : ~last;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx      <= 2'h0;
            wait_cnt <= 4'h0;
            o_valid  <= 1'b0;
        end else if (i_go) begin
            idx      <= 2'h0;
            wait_cnt <= 4'h0;
            o_valid  <= 1'b1;
        end else if (o_valid && i_ready) begin
            idx      <= idx + 2'h1;
            wait_cnt <= i_gap;
            o_valid  <= (idx + 2'h1 < i_len) && (i_gap == 4'h0);
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
            o_valid  <= (wait_cnt == 4'h1) && (idx < i_len);
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last <= 8'h00;
        end else if (o_valid && i_ready) begin
            last <= o_byte;
        end
    end
endmodule // cdaw_prog_mem
`default_nettype wire

/* testbench/cdaw_core_test.sv */
// self-checking bench of the control and wide-arithmetic decoder
`timescale 1ns/100ps
`default_nettype none
module cdaw_core_test
    import cdaw_pkg::*;
;
    // fl: bit1 sample expected, bit0 half-carry left unchecked
    typedef struct packed {
        logic [15:0] prog;
        logic [4:0]  t;
        logic [2:0]  sel;
        logic [15:0] val;
        logic [7:0]  fexp;
        logic [1:0]  fl;
    } cdaw_row_s;
    logic        clk;
    logic        rst_n;
    logic        go;
    logic [15:0] prog;
    logic [1:0]  len;
    logic [3:0]  gap;
    logic        valid;
    logic [7:0]  op_byte;
    logic        ready;
    cdaw_regs_s  regs;
    logic        ien;
    logic [1:0]  imode;
    logic        halted;
    logic        done;
    logic        smp;
    logic [15:0] t_seen;
    logic        smp_seen;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          c;
    cdaw_regs_s  rst_exp = '{8'hFF, 8'hFF, 16'h0000, 16'h0000, 16'h0000,
                             16'hFFFF, 16'h0000, 16'h0000};
    cdaw_row_s   rows [0:28] = '{
        '{16'h0000,5'h04,3'h0,16'h00FF,8'hD7,2'h0},
        '{16'h44ED,5'h08,3'h0,16'h0001,8'h13,2'h0},
        '{16'h003F,5'h04,3'h0,16'h0001,8'h00,2'h1},
        '{16'h0037,5'h04,3'h0,16'h0001,8'h01,2'h0},
        '{16'h0027,5'h04,3'h0,16'h0061,8'h01,2'h0},
        '{16'h002F,5'h04,3'h0,16'h009E,8'h13,2'h0},
        '{16'h00FB,5'h04,3'h7,16'h0004,8'h13,2'h0},
        '{16'h56ED,5'h08,3'h7,16'h0005,8'h13,2'h2},
        '{16'h5EED,5'h08,3'h7,16'h0006,8'h13,2'h2},
        '{16'h46ED,5'h08,3'h7,16'h0004,8'h13,2'h2},
        '{16'h00F3,5'h04,3'h7,16'h0000,8'h13,2'h0},
        '{16'h0003,5'h06,3'h1,16'h0001,8'h13,2'h0},
        '{16'h0013,5'h06,3'h2,16'h0001,8'h13,2'h0},
        '{16'h0023,5'h06,3'h3,16'h0001,8'h13,2'h0},
        '{16'h0033,5'h06,3'h4,16'h0000,8'h13,2'h0},
        '{16'h003B,5'h06,3'h4,16'hFFFF,8'h13,2'h0},
        '{16'h0009,5'h0B,3'h3,16'h0002,8'h00,2'h1},
        '{16'h0019,5'h0B,3'h3,16'h0003,8'h00,2'h1},
        '{16'h0039,5'h0B,3'h3,16'h0002,8'h01,2'h1},
        '{16'h5AED,5'h0F,3'h3,16'h0004,8'h00,2'h1},
        '{16'h42ED,5'h0F,3'h3,16'h0003,8'h02,2'h1},
        '{16'h62ED,5'h0F,3'h3,16'h0000,8'h42,2'h1},
        '{16'h72ED,5'h0F,3'h3,16'h0001,8'h03,2'h1},
        '{16'h23DD,5'h0A,3'h5,16'h0001,8'h03,2'h1},
        '{16'h2BFD,5'h0A,3'h6,16'hFFFF,8'h03,2'h1},
        '{16'h29DD,5'h0F,3'h5,16'h0002,8'h00,2'h1},
        '{16'h29FD,5'h0F,3'h6,16'hFFFE,8'h01,2'h1},
        '{16'h09FD,5'h0F,3'h6,16'hFFFF,8'h00,2'h1},
        '{16'h39DD,5'h0F,3'h5,16'h0001,8'h01,2'h1}};
    // =====================================================
    // design and program memory
    cdaw_core cdaw_core_i (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_OP_VALID(valid), .I_OP_BYTE(op_byte), .O_OP_READY(ready),
        .O_REGS(regs), .O_IEN(ien), .O_IMODE(imode), .O_HALTED(halted),
        .O_DONE(done), .O_INT_SAMPLE(smp));
    cdaw_prog_mem cdaw_prog_mem_i (.i_clk(clk), .i_rst_n(rst_n),
        .i_go(go), .i_prog(prog), .i_len(len), .i_gap(gap),
        .i_ready(ready), .o_valid(valid), .o_byte(op_byte));
    // =====================================================
    // tasks
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [15:0] pick(input logic [2:0] s);
        case (s)
            3'h0: pick = {8'h00, regs.acc};
            3'h1: pick = regs.first_pair;
            3'h2: pick = regs.second_pair;
            3'h3: pick = regs.primary_pointer_pair;
            3'h4: pick = regs.stack_pointer;
            3'h5: pick = regs.first_index_register;
            3'h6: pick = regs.second_index_register;
            default: pick = {13'h0000, ien, imode};
        endcase
    endfunction
    // t_seen counts clock states from the first byte taken to done
    task automatic run(input logic [15:0] p, input logic [1:0] n,
                       input logic [3:0] g);
        @(posedge clk);
        prog <= p;
        len  <= n;
        gap  <= g;
        go   <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (!(valid && ready) && c < 40);
        t_seen = 16'h0001;
        while (done !== 1'b1 && t_seen < 16'h0028) begin
            @(negedge clk);
            t_seen++;
        end
        smp_seen = smp;
        @(negedge clk);
    endtask
    // =====================================================
    // stimulus
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        go    = 1'b0;
        prog  = 16'h0000;
        len   = 2'h1;
        gap   = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[k]) begin
            run(rows[k].prog, (rows[k].prog[15:8] != 8'h00) ? 2'h2 : 2'h1,
                4'h0);
            chk("states", t_seen, {11'h000, rows[k].t});
            chk("value", pick(rows[k].sel), rows[k].val);
            chk("flags", {8'h00, regs.flags & (rows[k].fl[0] ? 8'hC7 :
                8'hD7)}, {8'h00, rows[k].fexp});
            chk("sample", {15'h0000, smp_seen},
                {15'h0000, rows[k].fl[1]});
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("reset_state", {15'h0000, ({regs, ien, imode, halted} !==
            {rst_exp, 4'h0})}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        run(16'h44ED, 2'h2, 4'h6);
        chk("late_states", t_seen, 16'h000B);
        chk("late_acc", pick(3'h0), 16'h0001);
        run(16'h0000, 2'h2, 4'h0);
        c = 0;
        while (done !== 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        chk("back_to_back", c[15:0], 16'h0003);
        run(16'h0076, 2'h1, 4'h0);
        chk("halt_states", t_seen, 16'h0004);
        chk("halted", {15'h0000, halted}, 16'h0001);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        c = 0;
        repeat (10) begin
            @(negedge clk);
            if (ready !== 1'b0 || done !== 1'b0) c++;
        end
        chk("refused", c[15:0], 16'h0000);
        chk("halt_acc", pick(3'h0), 16'h0001);
        test_done();
    end
endmodule // cdaw_core_test
`default_nettype wire
